// *** wsp_top.sv ***
// Wake source selection and analog-digital shared pad isolation.
// Assumes wake pins and controls are synchronous to clk_sys_i.
// How it works
// - Hibernate wake: OR of masked wake pins
// - Sleep wake: one muxed pin, preselected
// - External slow clock frees crystal pin, pulled up
// - Reset or power-up isolates analog and digital
// - Converter pads stay isolated until switches configured
// - Configured pads follow programmed digital state
`timescale 1ns/1ps
module wsp_top #(
    parameter int PINS = wsp_pkg::WAKE_PINS,
    parameter int SW = wsp_pkg::SEL_W
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [PINS-1:0] wake_pins_i,
    input wire wsp_pkg::wsp_pstate_t pstate_i,
    input wire logic mask_we_i,
    input wire logic [PINS-1:0] mask_i,
    input wire logic sel_we_i,
    input wire logic [SW-1:0] sel_i,
    input wire logic ext_slow_clk_i,
    input wire logic xtal_n_out_i,
    input wire logic sw_cfg_done_i,
    input wire wsp_pkg::wsp_pad_cfg_t pad_cfg_i,
    output logic hib_wake_o,
    output logic low_power_deep_sleep_state_wake_o,
    output logic xtal_n_oe_o,
    output logic xtal_n_out_o,
    output logic xtal_n_pu_o,
    output logic sw_cfg_ok_o,
    output wsp_pkg::wsp_pad_drv_t pad_drv_o
);
    // ************************************************************
    // Wake selection
    // ************************************************************
    logic [PINS-1:0] mask_w;
    logic [SW-1:0] sel_w;
    logic hib_wake_ff;
    logic nxt_hib_wake;
    logic low_power_deep_sleep_state_wake_ff;
    logic nxt_low_power_deep_sleep_state_wake;

    wsp_sel_mem #(
        .PINS(PINS),
        .SW(SW)
    ) u_sel (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .mask_we_i(mask_we_i),
        .mask_i(mask_i),
        .sel_we_i(sel_we_i),
        .sel_i(sel_i),
        .mask_o(mask_w),
        .sel_o(sel_w)
    );

    // Each monitor looks only at its own setting and its own state
    always_comb begin
        nxt_hib_wake = 1'b0;
        nxt_low_power_deep_sleep_state_wake = 1'b0;
        if (pstate_i == wsp_pkg::WSP_HIB) begin
            nxt_hib_wake = |(wake_pins_i & mask_w);
        end
        if (pstate_i == wsp_pkg::WSP_LOW_POWER_DEEP_SLEEP_STATE) begin
            nxt_low_power_deep_sleep_state_wake = wake_pins_i[sel_w];
        end
    end

    // Wake flags are levels, one cycle behind the pins
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            hib_wake_ff <= 1'b0;
            low_power_deep_sleep_state_wake_ff <= 1'b0;
        end else begin
            hib_wake_ff <= nxt_hib_wake;
            low_power_deep_sleep_state_wake_ff <= nxt_low_power_deep_sleep_state_wake;
        end
    end

    // ************************************************************
    // Slow crystal negative pin
    // ************************************************************
    logic xtal_oe_ff;
    logic nxt_xtal_oe;
    logic xtal_out_ff;
    logic nxt_xtal_out;
    logic xtal_pu_ff;
    logic nxt_xtal_pu;

    // Pin is output-only when freed; never an input
    always_comb begin
        nxt_xtal_oe = ext_slow_clk_i;
        nxt_xtal_pu = ext_slow_clk_i;
        nxt_xtal_out = ext_slow_clk_i & xtal_n_out_i;
    end

    // Crystal pin drive registers
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            xtal_oe_ff <= 1'b0;
            xtal_out_ff <= 1'b0;
            xtal_pu_ff <= 1'b0;
        end else begin
            xtal_oe_ff <= nxt_xtal_oe;
            xtal_out_ff <= nxt_xtal_out;
            xtal_pu_ff <= nxt_xtal_pu;
        end
    end

    // ************************************************************
    // Shared pad isolation
    // ************************************************************
    logic cfg_ok_ff;
    logic nxt_cfg_ok;
    wsp_pkg::wsp_pad_drv_t drv_ff;
    wsp_pkg::wsp_pad_drv_t nxt_drv;

    // Configured flag is sticky until the next reset; it holds in
    // every power mode so the pads do not glitch on sleep entry
    always_comb begin
        nxt_cfg_ok = cfg_ok_ff | sw_cfg_done_i;
    end

    // Isolated pads drive nothing; configured pads copy the program
    always_comb begin
        nxt_drv = '0;
        if (cfg_ok_ff) begin
            nxt_drv.dig_out = pad_cfg_i.out;
            nxt_drv.dig_oe = pad_cfg_i.oe;
            nxt_drv.dig_pu = pad_cfg_i.pu;
            nxt_drv.dig_iso = 8'h00;
            nxt_drv.ana_iso = 8'h00;
        end else begin
            nxt_drv.dig_iso = wsp_pkg::RST_ISO;
            nxt_drv.ana_iso = wsp_pkg::RST_ISO;
        end
    end

    // Reset forces full isolation of both paths
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            cfg_ok_ff <= 1'b0;
            drv_ff <= '0;
            drv_ff.dig_iso <= wsp_pkg::RST_ISO;
            drv_ff.ana_iso <= wsp_pkg::RST_ISO;
        end else begin
            cfg_ok_ff <= nxt_cfg_ok;
            drv_ff <= nxt_drv;
        end
    end

    // Outputs straight from flops
    assign hib_wake_o = hib_wake_ff;
    assign low_power_deep_sleep_state_wake_o = low_power_deep_sleep_state_wake_ff;
    assign xtal_n_oe_o = xtal_oe_ff;
    assign xtal_n_out_o = xtal_out_ff;
    assign xtal_n_pu_o = xtal_pu_ff;
    assign sw_cfg_ok_o = cfg_ok_ff;
    assign pad_drv_o = drv_ff;
endmodule

// *** wsp_pkg.sv ***
// Package for the wake select and shared pad isolation block.
// Assumes a single 10 MHz system clock and a synchronous active-low reset.
package wsp_pkg;
    // ************************************************************
    // Sizes and reset values
    // ************************************************************
    localparam int WAKE_PINS = 8;
    localparam int SEL_W = 3;
    localparam int SHARED_PADS = 8;
    localparam logic [7:0] RST_HIB_MASK = 8'h00;
    localparam logic [2:0] RST_LOW_POWER_DEEP_SLEEP_STATE_SEL = 3'h0;
    localparam logic [7:0] RST_ISO = 8'hff;

    // Power states as seen by the wake monitor
    typedef enum logic [1:0] {
        WSP_ACTIVE,
        WSP_LOW_POWER_DEEP_SLEEP_STATE,
        WSP_HIB
    } wsp_pstate_t;

    // Per-pad programmed digital state
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } wsp_pad_cfg_t;

    // Drive toward the pad ring
    typedef struct packed {
        logic [7:0] dig_out;
        logic [7:0] dig_oe;
        logic [7:0] dig_pu;
        logic [7:0] dig_iso;
        logic [7:0] ana_iso;
    } wsp_pad_drv_t;
endpackage

// *** wsp_sel_mem.sv ***
// Small configuration store: hibernate wake mask and sleep pin select.
// Assumes the power controller loads it before entering a low-power state.
`timescale 1ns/1ps
module wsp_sel_mem #(
    parameter int PINS = wsp_pkg::WAKE_PINS,
    parameter int SW = wsp_pkg::SEL_W
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic mask_we_i,
    input wire logic [PINS-1:0] mask_i,
    input wire logic sel_we_i,
    input wire logic [SW-1:0] sel_i,
    output logic [PINS-1:0] mask_o,
    output logic [SW-1:0] sel_o
);
    logic [PINS-1:0] mask_ff;
    logic [PINS-1:0] nxt_mask;
    logic [SW-1:0] sel_ff;
    logic [SW-1:0] nxt_sel;

    // Next values of the stored settings
    always_comb begin
        nxt_mask = mask_we_i ? mask_i : mask_ff;
        nxt_sel = sel_we_i ? sel_i : sel_ff;
    end

    // Registered store, read data straight from the flops
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            mask_ff <= PINS'(wsp_pkg::RST_HIB_MASK);
            sel_ff <= SW'(wsp_pkg::RST_LOW_POWER_DEEP_SLEEP_STATE_SEL);
        end else begin
            mask_ff <= nxt_mask;
            sel_ff <= nxt_sel;
        end
    end

    assign mask_o = mask_ff;
    assign sel_o = sel_ff;
endmodule

// *** wsp_chk.sv ***
// Checker of the wake and pad rules, bound to wsp_top.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module wsp_chk #(parameter int PINS = 8, parameter int SW = 3) (
    input wire logic clk_sys_i, reset_n_i, mask_we_i, sel_we_i,
    input wire logic ext_slow_clk_i, xtal_n_out_i, sw_cfg_done_i,
    input wire logic hib_wake_o, low_power_deep_sleep_state_wake_o, sw_cfg_ok_o,
    input wire logic xtal_n_oe_o, xtal_n_out_o, xtal_n_pu_o,
    input wire logic [PINS-1:0] wake_pins_i, mask_i,
    input wire logic [SW-1:0] sel_i,
    input wire wsp_pkg::wsp_pstate_t pstate_i,
    input wire wsp_pkg::wsp_pad_cfg_t pad_cfg_i,
    input wire wsp_pkg::wsp_pad_drv_t pad_drv_o
);
    // Shadows of the stored settings, since wake uses stored values
    logic [PINS-1:0] m_ff;
    logic [SW-1:0] s_ff;
    logic r_ff;
    always_ff @(posedge clk_sys_i) begin
        r_ff <= reset_n_i;
        m_ff <= !reset_n_i ? '0 : mask_we_i ? mask_i : m_ff;
        s_ff <= !reset_n_i ? '0 : sel_we_i ? sel_i : s_ff;
    end
    default clocking @(posedge clk_sys_i); endclocking
    // Skip the edge after release, where $past still sees reset
    default disable iff (!reset_n_i || !r_ff);
    a_hib_mask_or:
    assert property (hib_wake_o == $past(pstate_i == wsp_pkg::WSP_HIB
        && |(wake_pins_i & m_ff))) else $error("hib wake");
    a_low_power_deep_sleep_state_one_pin:
    assert property (low_power_deep_sleep_state_wake_o == $past(pstate_i == wsp_pkg::WSP_LOW_POWER_DEEP_SLEEP_STATE
        && wake_pins_i[s_ff])) else $error("low_power_deep_sleep_state wake");
    a_xtal_freed:
    assert property ({xtal_n_oe_o, xtal_n_pu_o, xtal_n_out_o} == $past({
        {2{ext_slow_clk_i}}, ext_slow_clk_i & xtal_n_out_i})) else $error("xtal");
    a_reset_iso:
    assert property (disable iff (1'b0) !reset_n_i |=> &pad_drv_o[15:0]
        && !sw_cfg_ok_o) else $error("reset iso");
    a_iso_until_cfg:
    assert property (!sw_cfg_ok_o |=> &pad_drv_o[15:0]) else $error("iso");
    a_cfg_sticky:
    assert property (sw_cfg_done_i || sw_cfg_ok_o |=> sw_cfg_ok_o)
        else $error("cfg flag");
    a_pads_follow:
    assert property (sw_cfg_ok_o |=> pad_drv_o == {$past(pad_cfg_i), 16'h0000})
        else $error("pad state");
endmodule
bind wsp_top wsp_chk #(.PINS(PINS), .SW(SW)) i_chk (.*);

// *** wsp_board.sv ***
// Board model driving the wake pins.
// Assumes the pattern is set before each falling edge.
`timescale 1ns/1ps
module wsp_board (
    input wire logic clk_i,
    input wire logic [7:0] pat_i,
    output logic [7:0] pins_o = 8'h00
);
    // Change on the falling edge, clear of the sampling edge
    always @(negedge clk_i) pins_o <= pat_i;
endmodule

// *** tb.sv ***
// Bench: random drive, queued notes, compare when outputs settle.
// Assumes design, board model and bound checker compiled first.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [5:0] w;
        logic [24:0] pad;
    } wsp_note_t;
    logic clk_sys_i = 0, reset_n_i = 0, mask_we_i = 0, sel_we_i = 0;
    logic ext_slow_clk_i = 0, xtal_n_out_i = 0, sw_cfg_done_i = 0;
    logic hib_wake_o, low_power_deep_sleep_state_wake_o, xtal_n_oe_o, xtal_n_out_o;
    logic xtal_n_pu_o, sw_cfg_ok_o, ok_ref = 0, rst_prv = 0;
    logic [7:0] wake_pins_i, mask_i = 0, pat = 0, m_ref = 0;
    logic [2:0] sel_i = 0, s_ref = 0;
    logic [31:0] rnd = 32'hc0b88cbd;
    wsp_pkg::wsp_pstate_t pstate_i = wsp_pkg::WSP_ACTIVE;
    wsp_pkg::wsp_pad_cfg_t pad_cfg_i = '0;
    wsp_pkg::wsp_pad_drv_t pad_drv_o;
    wsp_note_t q[$], n, e;
    int n_mismatch = 0, n_compared = 0;
    wire logic [5:0] flg = {hib_wake_o, low_power_deep_sleep_state_wake_o, xtal_n_oe_o,
        xtal_n_out_o, xtal_n_pu_o, sw_cfg_ok_o};
    wsp_board i_board (.clk_i(clk_sys_i), .pat_i(pat), .pins_o(wake_pins_i));
    wsp_top i_dut (.*);
    initial forever #50 clk_sys_i = ~clk_sys_i;
    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task chk(input string s, input logic [24:0] x, y);
        n_compared++;
        if (y !== x) begin
            n_mismatch++;
            $display("[ERR] %s exp %h got %h", s, x, y);
        end
    endtask
    task print_verdict();
        if (n_mismatch == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // One cycle of drive; first cycle after reset kept quiet
    task step(input logic r, d);
        @(posedge clk_sys_i);
        rnd = lfsr(rnd);
        pat = rnd[7:0];
        @(negedge clk_sys_i);
        reset_n_i = r;
        pstate_i = wsp_pkg::wsp_pstate_t'(rst_prv && rnd[9:8] != 2'h3 ?
            rnd[9:8] : 2'h0);
        {mask_we_i, sel_we_i, xtal_n_out_i} = rnd[12:10];
        ext_slow_clk_i = rst_prv & rnd[13];
        mask_i = rnd[23:16];
        sel_i = rnd[26:24];
        pad_cfg_i = rnd[31:8];
        sw_cfg_done_i = d;
        n.w = {pstate_i == wsp_pkg::WSP_HIB && |(pat & m_ref),
            pstate_i == wsp_pkg::WSP_LOW_POWER_DEEP_SLEEP_STATE && pat[s_ref], ext_slow_clk_i,
            ext_slow_clk_i & xtal_n_out_i, ext_slow_clk_i, ok_ref | d} & {6{r}};
        n.pad = {r && ok_ref, pad_cfg_i};
        q.push_back(n);
        ok_ref = r && (ok_ref || d);
        m_ref = !r ? '0 : mask_we_i ? mask_i : m_ref;
        s_ref = !r ? '0 : sel_we_i ? sel_i : s_ref;
        rst_prv = r;
    endtask
    // Take the oldest note once the edge has settled
    always @(posedge clk_sys_i) begin
        #10;
        if (q.size() > 0) begin
            e = q.pop_front();
            chk("wake", e.w[5:4], flg[5:4]);
            chk("xtal", e.w[3:1], flg[3:1]);
            chk("cfg_ok", e.w[0], flg[0]);
            chk("iso", e.pad[24] ? 16'h0 : 16'hffff, pad_drv_o[15:0]);
            if (e.pad[24]) chk("pad", e.pad[23:0], pad_drv_o[39:16]);
        end
    end
    // Reset, long isolated stretch, config, mid-run reset, repeat
    initial begin
        for (int i = 0; i < 200; i++)
            step(i > 1 && i != 120, i == 70 || i == 150 || i == 151);
        @(posedge clk_sys_i);
        #20;
        print_verdict();
    end
endmodule
